// ### logic/bmc_device_end.sv
// Local end: transmit buffer, biphase-mark codec and CC wire steering
`timescale 1ns/10ps

// ------------------------------------------------------------------
// Synchronous FIFO
// ------------------------------------------------------------------
module bmc_fifo #(
  parameter int W = 2,
  parameter int D = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         inValid,
  input  wire logic [W-1:0] inData,
  output logic              inReady,
  output logic              outValid,
  output logic [W-1:0]      outData,
  input  wire logic         outReady
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   count;
  } bmc_fifo_state_t;

  bmc_fifo_state_t s_reg;
  bmc_fifo_state_t s_next;
  logic [W-1:0]    mem [D];
  logic            doPush;
  logic            doPop;

  // No space is offered while held in reset, so no word is silently lost
  assign inReady  = !rst && (s_reg.count != (AW+1)'(D));
  assign outValid = (s_reg.count != '0);
  assign outData  = mem[s_reg.rp];
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;

  always_comb
  begin
    s_next = s_reg;
    if (doPush)
    begin
      s_next.wp = (s_reg.wp == AW'(D - 1)) ? '0 : s_reg.wp + 1'b1;
    end
    if (doPop)
    begin
      s_next.rp = (s_reg.rp == AW'(D - 1)) ? '0 : s_reg.rp + 1'b1;
    end
    s_next.count = s_reg.count + (AW+1)'(doPush) - (AW+1)'(doPop);
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Storage needs no reset; only words under count are ever read
  always_ff @(posedge ref_clk)
  begin
    if (doPush)
    begin
      mem[s_reg.wp] <= inData;
    end
  end
endmodule

// ------------------------------------------------------------------
// Biphase-mark encoder and interval-timing decoder
// ------------------------------------------------------------------
module bmc_codec (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic txValid,
  input  wire logic txData,
  input  wire logic txLast,
  output logic      txReady,
  output logic      lineOut,
  output logic      lineOe,
  input  wire logic rxLine,
  output logic      rxValid,
  output logic      rxData,
  output logic      rxEnd,
  output logic      rxBusy
);
  typedef struct packed {
    bmc_pkg::bmc_tx_state_t       tx;
    bmc_pkg::bmc_rx_state_t       rx;
    logic [bmc_pkg::CNT_W-1:0]    cnt;
    logic [bmc_pkg::CNT_W-1:0]    rcnt;
    logic                         line;
    logic                         oe;
    logic                         bitVal;
    logic                         last;
    logic                         prev;
    logic                         pend;
    logic                         rxValid;
    logic                         rxData;
    logic                         rxEnd;
  } bmc_codec_state_t;

  localparam bmc_codec_state_t RESET_STATE = '{
    tx: bmc_pkg::TX_IDLE, rx: bmc_pkg::RX_IDLE, cnt: '0, rcnt: '0,
    line: bmc_pkg::LINE_BIAS, oe: 1'b0, bitVal: 1'b0, last: 1'b0,
    prev: bmc_pkg::LINE_BIAS, pend: 1'b0, rxValid: 1'b0, rxData: 1'b0, rxEnd: 1'b0};

  bmc_codec_state_t s_reg;
  bmc_codec_state_t s_next;
  logic             edgeSeen;

  assign edgeSeen = (rxLine != s_reg.prev);
  assign lineOut  = s_reg.line;
  assign lineOe   = s_reg.oe;
  assign rxValid  = s_reg.rxValid;
  assign rxData   = s_reg.rxData;
  assign rxEnd    = s_reg.rxEnd;
  assign rxBusy   = (s_reg.rx != bmc_pkg::RX_IDLE);

  always_comb
  begin
    s_next         = s_reg;
    txReady        = 1'b0;
    s_next.rxValid = 1'b0;
    s_next.rxEnd   = 1'b0;
    s_next.prev    = rxLine;

    // ----------------------------------------------------------------
    // Transmit
    // ----------------------------------------------------------------
    case (s_reg.tx)
      bmc_pkg::TX_IDLE:
      begin
        s_next.cnt = bmc_pkg::CNT_ZERO;
        // Never start over a frame already on the wire
        if (txValid && s_reg.rx == bmc_pkg::RX_IDLE && !edgeSeen)
        begin
          s_next.tx   = bmc_pkg::TX_PRE;
          s_next.oe   = 1'b1;
          s_next.line = 1'b0;
        end
      end
      bmc_pkg::TX_PRE:
      begin
        if (s_reg.cnt == bmc_pkg::PRE_LAST)
        begin
          s_next.tx  = bmc_pkg::TX_BIT;
          s_next.cnt = bmc_pkg::CNT_ZERO;
        end
        else
        begin
          s_next.cnt = s_reg.cnt + bmc_pkg::CNT_ONE;
        end
      end
      bmc_pkg::TX_BIT:
      begin
        if (s_reg.cnt == bmc_pkg::CNT_ZERO)
        begin
          if (txValid)
          begin
            txReady       = 1'b1;
            s_next.line   = ~s_reg.line;
            s_next.bitVal = txData;
            s_next.last   = txLast;
            s_next.cnt    = bmc_pkg::CNT_ONE;
          end
          else
          begin
            // Underrun closes at once, so the last bit is not stretched
            s_next.line = ~s_reg.line;
            s_next.tx   = bmc_pkg::TX_END;
            s_next.cnt  = bmc_pkg::CNT_ONE;
          end
        end
        else
        begin
          // Equal half cells keep the running imbalance bounded
          if (s_reg.cnt == bmc_pkg::HALF_CNT && s_reg.bitVal)
          begin
            s_next.line = ~s_reg.line;
          end
          if (s_reg.cnt == bmc_pkg::BIT_LAST)
          begin
            s_next.cnt = bmc_pkg::CNT_ZERO;
            if (s_reg.last)
            begin
              s_next.tx = bmc_pkg::TX_END;
            end
          end
          else
          begin
            s_next.cnt = s_reg.cnt + bmc_pkg::CNT_ONE;
          end
        end
      end
      bmc_pkg::TX_END:
      begin
        if (s_reg.cnt == bmc_pkg::CNT_ZERO)
        begin
          s_next.line = ~s_reg.line;
          s_next.cnt  = bmc_pkg::CNT_ONE;
        end
        else if (s_reg.cnt == bmc_pkg::HALF_CNT)
        begin
          s_next.oe   = 1'b0;
          s_next.line = bmc_pkg::LINE_BIAS;
          s_next.tx   = bmc_pkg::TX_IDLE;
          s_next.cnt  = bmc_pkg::CNT_ZERO;
        end
        else
        begin
          s_next.cnt = s_reg.cnt + bmc_pkg::CNT_ONE;
        end
      end
      default:
      begin
        s_next.tx = bmc_pkg::TX_IDLE;
      end
    endcase

    // ----------------------------------------------------------------
    // Receive
    // ----------------------------------------------------------------
    if (s_reg.oe)
    begin
      // Own echo is not decoded
      s_next.rx   = bmc_pkg::RX_IDLE;
      s_next.rcnt = bmc_pkg::CNT_ZERO;
    end
    else
    begin
      case (s_reg.rx)
        bmc_pkg::RX_IDLE:
        begin
          s_next.rcnt = bmc_pkg::CNT_ZERO;
          if (edgeSeen)
          begin
            s_next.rx   = bmc_pkg::RX_SYNC;
            s_next.pend = 1'b0;
          end
        end
        bmc_pkg::RX_SYNC, bmc_pkg::RX_RUN:
        begin
          if (edgeSeen)
          begin
            s_next.rcnt = bmc_pkg::CNT_ZERO;
            // First interval is thrown away, so a lost edge costs no lock
            if (s_reg.rx == bmc_pkg::RX_SYNC)
            begin
              s_next.rx = bmc_pkg::RX_RUN;
            end
            else if (s_reg.rcnt < bmc_pkg::SHORT_MAX)
            begin
              s_next.pend = ~s_reg.pend;
              if (s_reg.pend)
              begin
                s_next.rxValid = 1'b1;
                s_next.rxData  = 1'b1;
              end
            end
            else
            begin
              s_next.pend    = 1'b0;
              s_next.rxValid = 1'b1;
              s_next.rxData  = 1'b0;
            end
          end
          else if (s_reg.rcnt == bmc_pkg::RX_TMO)
          begin
            s_next.rx    = bmc_pkg::RX_IDLE;
            s_next.rxEnd = (s_reg.rx == bmc_pkg::RX_RUN);
          end
          else
          begin
            s_next.rcnt = s_reg.rcnt + bmc_pkg::CNT_ONE;
          end
        end
        default:
        begin
          s_next.rx = bmc_pkg::RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s_reg <= RESET_STATE;
    end
    else
    begin
      s_reg <= s_next;
    end
  end
endmodule

// ------------------------------------------------------------------
// Local device end
// ------------------------------------------------------------------
module bmc_device_end (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic porGood,
  input  wire logic orientSecond,
  input  wire logic txValid,
  input  wire logic txData,
  input  wire logic txLast,
  output logic      txReady,
  output logic      rxValid,
  output logic      rxData,
  output logic      rxEnd,
  output logic      txActive,
  bmc_cc_if.device  cc
);
  typedef struct packed {
    logic coreRst;
    logic orient;
  } bmc_dev_state_t;

  bmc_dev_state_t             s_reg;
  bmc_dev_state_t             s_next;
  logic [bmc_pkg::FIFO_W-1:0] fifoOut;
  logic                       fifoValid;
  logic                       fifoPop;
  logic                       lineOut;
  logic                       lineOe;
  logic                       rxLine;
  logic                       rxBusy;

  always_comb
  begin
    s_next         = s_reg;
    s_next.coreRst = !porGood;
    // Orientation only moves between frames
    if (!lineOe && !rxBusy)
    begin
      s_next.orient = orientSecond;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s_reg <= '{coreRst: 1'b1, orient: 1'b0};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  bmc_fifo #(
    .W (bmc_pkg::FIFO_W),
    .D (bmc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .rst      (s_reg.coreRst),
    .inValid  (txValid),
    .inData   ({txLast, txData}),
    .inReady  (txReady),
    .outValid (fifoValid),
    .outData  (fifoOut),
    .outReady (fifoPop)
  );

  bmc_codec u_codec (
    .ref_clk (ref_clk),
    .rst     (s_reg.coreRst),
    .txValid (fifoValid),
    .txData  (fifoOut[bmc_pkg::WORD_BIT]),
    .txLast  (fifoOut[bmc_pkg::WORD_LAST]),
    .txReady (fifoPop),
    .lineOut (lineOut),
    .lineOe  (lineOe),
    .rxLine  (rxLine),
    .rxValid (rxValid),
    .rxData  (rxData),
    .rxEnd   (rxEnd),
    .rxBusy  (rxBusy)
  );

  assign txActive        = lineOe;
  assign cc.devFirstOut  = lineOut;
  assign cc.devSecondOut = lineOut;
  assign cc.devFirstOe   = lineOe && !s_reg.orient;
  assign cc.devSecondOe  = lineOe && s_reg.orient;
  assign rxLine          = s_reg.orient ? cc.ccSecond : cc.ccFirst;
endmodule

// ### include/bmc_pkg.sv
// Shared constants and types for the biphase-mark CC line coder
// Function
// - Every bit starts with a level change
// - One bits add a mid-bit level change
// - Line imbalance stays within one bit
// - Transmitter drives low before the first edge
// - Receiver survives losing the first preamble edge
// - One closing edge follows the final bit
// - Driver enabled only while sending a packet
// - Use only the orientation-selected CC wire
// - One talker at a time, others high impedance
// - Logic held in reset until supply good
package bmc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int BIT_TIME_NS   = 3200;
  localparam int BIT_CYC       = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 11;

  localparam logic [CNT_W-1:0] BIT_LAST  = CNT_W'(BIT_CYC - 1);
  localparam logic [CNT_W-1:0] HALF_CNT  = CNT_W'(BIT_CYC / 2);
  localparam logic [CNT_W-1:0] PRE_LAST  = CNT_W'(BIT_CYC - 1);
  localparam logic [CNT_W-1:0] SHORT_MAX = CNT_W'((BIT_CYC * 3) / 4);
  localparam logic [CNT_W-1:0] RX_TMO    = CNT_W'(BIT_CYC + BIT_CYC / 2);
  localparam logic [CNT_W-1:0] CNT_ZERO  = 11'h000;
  localparam logic [CNT_W-1:0] CNT_ONE   = 11'h001;

  // ----------------------------------------------------------------
  // Buffer and line
  // ----------------------------------------------------------------
  localparam int   FIFO_DEPTH = 8;
  localparam int   FIFO_W     = 2;
  localparam int   WORD_BIT   = 0;
  localparam int   WORD_LAST  = 1;
  localparam logic LINE_BIAS  = 1'h1;

  typedef enum logic [1:0] {TX_IDLE, TX_PRE, TX_BIT, TX_END} bmc_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_SYNC, RX_RUN} bmc_rx_state_t;

endpackage

// ### include/bmc_cc_if.sv
// Two CC wires shared by the local coder and the partner
`timescale 1ns/10ps
interface bmc_cc_if;
  logic devFirstOut;
  logic devFirstOe;
  logic devSecondOut;
  logic devSecondOe;
  logic partOut;
  logic partOe;
  logic partOnSecond;
  logic ccFirst;
  logic ccSecond;
  logic partLine;

  // Undriven wire floats back to the attach bias
  assign ccFirst  = devFirstOe ? devFirstOut :
                    ((partOe && !partOnSecond) ? partOut : bmc_pkg::LINE_BIAS);
  assign ccSecond = devSecondOe ? devSecondOut :
                    ((partOe && partOnSecond) ? partOut : bmc_pkg::LINE_BIAS);
  assign partLine = partOnSecond ? ccSecond : ccFirst;

  modport device (
    output devFirstOut,
    output devFirstOe,
    output devSecondOut,
    output devSecondOe,
    input  ccFirst,
    input  ccSecond
  );

  modport partner (
    output partOut,
    output partOe,
    input  partLine
  );
endinterface

// ### logic/bmc_partner_end.sv
// Far end: partner controller or cable marker on one CC wire
`timescale 1ns/10ps
module bmc_partner_end (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic txValid,
  input  wire logic txData,
  input  wire logic txLast,
  output logic      txReady,
  output logic      rxValid,
  output logic      rxData,
  output logic      rxEnd,
  output logic      txActive,
  bmc_cc_if.partner cc
);
  logic lineOut;
  logic lineOe;

  // Same coder keeps both ends on one timing and one decode rule
  bmc_codec u_codec (
    .ref_clk (ref_clk),
    .rst     (rst),
    .txValid (txValid),
    .txData  (txData),
    .txLast  (txLast),
    .txReady (txReady),
    .lineOut (lineOut),
    .lineOe  (lineOe),
    .rxLine  (cc.partLine),
    .rxValid (rxValid),
    .rxData  (rxData),
    .rxEnd   (rxEnd),
    .rxBusy  ()
  );

  assign txActive   = lineOe;
  assign cc.partOut = lineOut;
  assign cc.partOe  = lineOe;
endmodule

// ### tb/bmc_line_properties.sv
// Concurrent checks on the CC wires between the two coder ends
`timescale 1ns/10ps
module bmc_line_properties (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic devFirstOut,
  input wire logic devFirstOe,
  input wire logic devSecondOut,
  input wire logic devSecondOe,
  input wire logic partOut,
  input wire logic partOe,
  input wire logic partOnSecond
);
  logic        devOe;
  logic        devLine;
  logic        lineChg;
  logic        lastOe;
  logic        lastLine;
  logic        firstRun;
  logic [10:0] runReg;

  assign devOe   = devFirstOe | devSecondOe;
  assign devLine = devFirstOe ? devFirstOut : devSecondOut;
  assign lineChg = devOe && lastOe && (devLine != lastLine);

  // ----------------------------------------------------------------
  // Length of the level being driven
  // ----------------------------------------------------------------
  // Preamble run is exempt: its length may differ by one cycle
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      lastOe   <= 1'b0;
      lastLine <= 1'b1;
      firstRun <= 1'b1;
      runReg   <= 11'h000;
    end
    else
    begin
      lastOe   <= devOe;
      lastLine <= devLine;
      firstRun <= devOe ? (firstRun && !lineChg) : 1'b1;
      runReg   <= !devOe ? 11'h000 : (lineChg ? 11'h001 : runReg + 11'h001);
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  one_wire_a: assert property (!(devFirstOe && devSecondOe))
    else $error("both wires driven by device");
  one_talker_a: assert property (!(partOe && (partOnSecond ? devSecondOe : devFirstOe)))
    else $error("two talkers on one wire");
  dev_preamble_a: assert property ($rose(devOe) |-> !devLine)
    else $error("device preamble not low");
  part_preamble_a: assert property ($rose(partOe) |-> (!partOut) [*8])
    else $error("partner preamble not low");
  bit_runs_a: assert property (lineChg && !firstRun |-> runReg == 11'h140 || runReg == 11'h280)
    else $error("bit level run of wrong length");
  closing_half_a: assert property ($fell(devOe) |-> runReg >= 11'h13f && runReg <= 11'h141)
    else $error("closing level not half a bit");
  driver_idle_a: assert property (devOe |-> runReg <= 11'h281)
    else $error("driver enabled without coded edges");
  part_steady_a: assert property (partOe && $past(partOe) && $changed(partOut) |=> $stable(partOut) [*8])
    else $error("partner level too short");
endmodule

// ### tb/bmc_cc_line_phy_bench.sv
// Bench joining the device end and the partner end over the CC wires
`timescale 1ns/10ps
module bmc_cc_line_phy_bench;
  localparam int LIMIT = 60000;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        porGood = 1'b0;
  logic        orientSecond = 1'b0;
  logic        dTxValid = 1'b0, dTxData = 1'b0, dTxLast = 1'b0;
  logic        pTxValid = 1'b0, pTxData = 1'b0, pTxLast = 1'b0;
  logic        dTxReady, dRxValid, dRxData, dRxEnd, dTxActive;
  logic        pTxReady, pRxValid, pRxData, pRxEnd, pTxActive;
  logic        dGot[$], pGot[$], expQ[$], rxQ[$];
  int          failures = 0, checks = 0, cycles = 0, dEnds = 0, pEnds = 0;
  int unsigned seedDummy;

  bmc_cc_if cc ();

  always #2.5 ref_clk = ~ref_clk;

  bmc_device_end u_bmc_device_end (
    .ref_clk(ref_clk), .rst(rst), .porGood(porGood), .orientSecond(orientSecond),
    .txValid(dTxValid), .txData(dTxData), .txLast(dTxLast), .txReady(dTxReady),
    .rxValid(dRxValid), .rxData(dRxData), .rxEnd(dRxEnd), .txActive(dTxActive),
    .cc(cc)
  );
  bmc_partner_end u_bmc_partner_end (
    .ref_clk(ref_clk), .rst(rst),
    .txValid(pTxValid), .txData(pTxData), .txLast(pTxLast), .txReady(pTxReady),
    .rxValid(pRxValid), .rxData(pRxData), .rxEnd(pRxEnd), .txActive(pTxActive),
    .cc(cc)
  );
  bmc_line_properties u_bmc_line_properties (
    .ref_clk(ref_clk), .rst(rst),
    .devFirstOut(cc.devFirstOut), .devFirstOe(cc.devFirstOe),
    .devSecondOut(cc.devSecondOut), .devSecondOe(cc.devSecondOe),
    .partOut(cc.partOut), .partOe(cc.partOe), .partOnSecond(cc.partOnSecond)
  );

  // ----------------------------------------------------------------
  // Collection, checking and closing
  // ----------------------------------------------------------------
  // Sampled mid-cycle so registered pulses have settled
  always @(negedge ref_clk)
  begin
    cycles++;
    if (dRxValid === 1'b1) dGot.push_back(dRxData);
    if (pRxValid === 1'b1) pGot.push_back(pRxData);
    if (dRxEnd === 1'b1) dEnds++;
    if (pRxEnd === 1'b1) pEnds++;
    if (cycles == LIMIT)
    begin
      failures++;
      end_of_test();
    end
  end

  task automatic check_bit(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_count(input string what, input int exp, input int got);
    checks++;
    if (got != exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  function automatic int expected_bits(input logic orient, input logic onSecond, input int n);
    return (orient == onSecond) ? n : 0;
  endfunction

  // ----------------------------------------------------------------
  // One packet from one end; pat 0 random, 1 all ones, 2 all zeros
  // ----------------------------------------------------------------
  task automatic run_case(input logic fromPart, input logic orient, input logic onSecond,
                          input int n, input int pat, input logic lateWake);
    int   guard;
    int   endsAt;
    int   expN;
    logic b;
    expQ.delete();
    dGot.delete();
    pGot.delete();
    endsAt = fromPart ? dEnds : pEnds;
    expN = expected_bits(orient, onSecond, n);
    orientSecond = orient;
    cc.partOnSecond = onSecond;
    // Receiving core asleep through the first preamble edge
    if (lateWake) porGood = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      b = (pat == 0) ? 1'($urandom) : (pat == 1);
      expQ.push_back(b);
      dTxValid = !fromPart;
      pTxValid = fromPart;
      dTxData = b;
      pTxData = b;
      dTxLast = (i == n - 1);
      pTxLast = (i == n - 1);
      // Codec holds the first word through the preamble, so the buffer fills
      if (!fromPart && i == 8)
      begin
        check_bit("buffer ready when full", 1'b0, dTxReady);
        check_bit("driver active", 1'b1, dTxActive);
        check_bit("second wire enable", orient, cc.devSecondOe);
        check_bit("first wire enable", !orient, cc.devFirstOe);
      end
      guard = 0;
      while ((fromPart ? pTxReady : dTxReady) !== 1'b1 && guard < 2000)
      begin
        if (lateWake && i == 0 && guard == 100)
        begin
          check_bit("ready while supply low", 1'b0, dTxReady);
          porGood = 1'b1;
        end
        @(negedge ref_clk);
        guard++;
      end
      check_count("push accepted", 1, int'(guard < 2000));
      @(negedge ref_clk);
    end
    dTxValid = 1'b0;
    pTxValid = 1'b0;
    guard = 0;
    // A full buffer still holds eight bits after the last push
    while ((fromPart ? pTxActive : dTxActive) !== 1'b0 && guard < 7000)
    begin
      @(negedge ref_clk);
      guard++;
    end
    check_count("release in time", 1, int'(guard < 7000));
    // Covers the receive timeout and the sync started by the release edge
    repeat (1200) @(negedge ref_clk);
    check_bit("driver released", 1'b0, fromPart ? pTxActive : dTxActive);
    if (fromPart) rxQ = dGot;
    else rxQ = pGot;
    check_count("bits received", expN, rxQ.size());
    for (int i = 0; i < expN && i < rxQ.size(); i++)
      check_bit("bit value", expQ[i], rxQ[i]);
    check_count("frame ends", int'(expN > 0), (fromPart ? dEnds : pEnds) - endsAt);
  endtask

  initial
  begin
    cc.partOnSecond = 1'b0;
    seedDummy = $urandom(32'h6bfd);
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    dTxValid = 1'b1;
    repeat (20) @(negedge ref_clk);
    check_bit("ready before supply good", 1'b0, dTxReady);
    check_bit("active before supply good", 1'b0, dTxActive);
    dTxValid = 1'b0;
    porGood = 1'b1;
    repeat (4) @(negedge ref_clk);
    check_bit("ready after supply good", 1'b1, dTxReady);
    run_case(1'b0, 1'b0, 1'b0, 12, 0, 1'b0);
    run_case(1'b1, 1'b0, 1'b0, 8, 0, 1'b1);
    run_case(1'b0, 1'b1, 1'b1, 9, 1, 1'b0);
    run_case(1'b1, 1'b1, 1'b1, 9, 2, 1'b0);
    run_case(1'b1, 1'b0, 1'b1, 6, 0, 1'b0);
    end_of_test();
  end
endmodule
